// ### ocf_consts.svh
// Constants for the overcurrent sample filter
`ifndef OCF_CONSTS_SVH
`define OCF_CONSTS_SVH
`define OCF_CLK_HZ 25000000
`define OCF_STARTUP_NS 3000
`define OCF_STARTUP_CYC ((`OCF_STARTUP_NS * (`OCF_CLK_HZ / 1000000) + 999) / 1000)
`define OCF_PERIPH_DIV 4
`define OCF_SAMPLE_GROUP 4
`define OCF_PWM_MTC_DLY 3
`define OCF_FLAG_MTC_DLY 1
`define OCF_MTC_DIV 2
`define OCF_REG_CTRL 32'h0000_0000
`define OCF_REG_STATUS 32'h0000_0004
`define OCF_REG_MASK 32'h0000_0008
`define OCF_CTRL_RESET 32'h0000_0000
`endif

// ### ocf_pkg.sv
// Types for the overcurrent sample filter
package ocf_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_START = 2'b01,
    ST_RUN = 2'b10
  } phase_t;
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } div_t;
endpackage

// ### ocf_divider.sv
// Clock enable divider producing one-cycle pulses
`timescale 1ns/1ps
module ocf_divider (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] div_max,
  output logic tick
);
  ocf_pkg::div_t s;
  ocf_pkg::div_t next_s;

  // Count up to div_max and pulse
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == div_max) begin
      next_s.cnt = 2'b00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 2'b01;
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// ### ocf_top.sv
// Overcurrent sampling filter with AHB-Lite register access
// Functional notes
// R1: After the comparator is enabled by clock enable or DAC enable, sampling waits a startup time of 3 us.
// R2: A rising comparator output turns the PWM outputs off after (1+x) groups of four peripheral ticks plus 3 timer ticks.
// R3: A counted event sets the current limit flag after (1+x) groups of four peripheral ticks plus 1 timer tick.
// R4: With filter setting 001 two groups of four consecutive high samples are required to accept an event.
// R5: With the filter off one group of four high samples suffices and PWM turns off on the third timer tick after the event.
// R6: The startup wait keeps a settling comparator from making false events.
// R7: A low sample restarts the consecutive sample count from zero.
`timescale 1ns/1ps
`include "ocf_consts.svh"
module ocf_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic COMP_IN,
  input wire logic [5:0] PWM_IN,
  output logic [5:0] MOTOR_PWM_OUTPUTS,
  output logic CURRENT_LIMIT_FLAG,
  output logic IRQ
);
  typedef struct packed {
    logic [31:0] rdata;
    logic wr_pend;
    logic [3:0] wr_addr;
    logic cke;
    logic dac;
    logic [2:0] filt;
    logic [1:0] status;
    logic [1:0] mask;
    ocf_pkg::phase_t phase;
    logic [7:0] start_cnt;
    logic [1:0] sync;
    logic prev_samp;
    logic [3:0] run;
    logic [3:0] pcnt;
    logic [1:0] pwm_dly;
    logic flag_dly;
    logic pwm_arm;
    logic flag_arm;
    logic pwm_off;
    logic flag;
    logic [5:0] pwm;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;
  logic periph_tick;
  logic mtc_tick;

  // Peripheral clock: 25 MHz divided by 4
  ocf_divider u_periph (
    .CLK(CLK),
    .RST(RST),
    .div_max(2'(`OCF_PERIPH_DIV - 1)),
    .tick(periph_tick)
  );

  // Motor timer clock enable derived in the same way
  ocf_divider u_mtc (
    .CLK(CLK),
    .RST(RST),
    .div_max(2'(`OCF_MTC_DIV - 1)),
    .tick(mtc_tick)
  );

  function automatic logic [3:0] word_sel(input logic [31:0] a);
    word_sel = a[5:2];
  endfunction

  // Whole behaviour
  always_comb begin
    logic addr_ok;
    logic samp;
    addr_ok = HSEL && HREADY && HTRANS[1];
    samp = 1'b0;
    next_s = s;
    next_s.sync = {s.sync[0], COMP_IN};
    next_s.wr_pend = 1'b0;
    // Register writes in data phase
    if (s.wr_pend) begin
      case (s.wr_addr)
        word_sel(`OCF_REG_CTRL): begin
          next_s.cke = HWDATA[0];
          next_s.dac = HWDATA[1];
          next_s.filt = HWDATA[6:4];
          if (HWDATA[7]) begin
            next_s.flag = 1'b0;
            next_s.pwm_off = 1'b0;
          end
        end
        word_sel(`OCF_REG_MASK): next_s.mask = HWDATA[1:0];
        default: ;
      endcase
    end
    // Address phase
    if (addr_ok) begin
      if (HWRITE) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = word_sel(HADDR);
      end else begin
        case (word_sel(HADDR))
          word_sel(`OCF_REG_CTRL): next_s.rdata = {24'h00_0000, s.flag, s.filt, 2'b00, s.dac, s.cke};
          word_sel(`OCF_REG_STATUS): begin
            next_s.rdata = {28'h000_0000, s.phase, s.status};
            next_s.status = 2'b00;
          end
          word_sel(`OCF_REG_MASK): next_s.rdata = {30'h0000_0000, s.mask};
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Enable and startup wait
    case (s.phase)
      ocf_pkg::ST_OFF: begin
        if (s.cke || s.dac) begin
          next_s.phase = ocf_pkg::ST_START; // see R1
          next_s.start_cnt = 8'h00;
        end
      end
      ocf_pkg::ST_START: begin
        if (!(s.cke || s.dac)) begin
          next_s.phase = ocf_pkg::ST_OFF;
        end else if (s.start_cnt == 8'(`OCF_STARTUP_CYC - 1)) begin
          next_s.phase = ocf_pkg::ST_RUN; // see R6
        end else begin
          next_s.start_cnt = s.start_cnt + 8'h01;
        end
      end
      ocf_pkg::ST_RUN: begin
        if (!(s.cke || s.dac)) begin
          next_s.phase = ocf_pkg::ST_OFF;
        end
      end
      default: next_s.phase = ocf_pkg::ST_OFF;
    endcase
    // Sampling on peripheral ticks
    if (s.phase != ocf_pkg::ST_RUN) begin
      next_s.run = 4'h0;
      next_s.pcnt = 4'h0;
    end else if (periph_tick) begin
      samp = s.sync[1];
      next_s.prev_samp = samp;
      if (!samp) begin
        next_s.run = 4'h0; // see R7
        next_s.pcnt = 4'h0;
      end else if (s.pcnt == 4'(`OCF_SAMPLE_GROUP - 1)) begin
        next_s.pcnt = 4'h0;
        if (s.run == {1'b0, s.filt}) begin
          next_s.run = 4'h0; // see R4
          next_s.pwm_arm = 1'b1; // see R2
          next_s.flag_arm = 1'b1; // see R3
          next_s.pwm_dly = 2'b00;
          next_s.flag_dly = 1'b0;
        end else begin
          next_s.run = s.run + 4'h1;
        end
      end else begin
        next_s.pcnt = s.pcnt + 4'h1; // see R5
      end
    end
    // Timer clock delays
    if (mtc_tick && s.pwm_arm) begin
      if (s.pwm_dly == 2'(`OCF_PWM_MTC_DLY - 1)) begin
        next_s.pwm_arm = 1'b0;
        next_s.pwm_off = 1'b1; // see R2
        next_s.status[0] = 1'b1;
      end else begin
        next_s.pwm_dly = s.pwm_dly + 2'b01;
      end
    end
    if (mtc_tick && s.flag_arm) begin
      next_s.flag_arm = 1'b0;
      next_s.flag = 1'b1; // see R3
      next_s.status[1] = 1'b1;
    end
    next_s.pwm = next_s.pwm_off ? 6'h00 : PWM_IN;
    next_s.irq = |(next_s.status & s.mask);
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign HRDATA = s.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MOTOR_PWM_OUTPUTS = s.pwm;
  assign CURRENT_LIMIT_FLAG = s.flag;
  assign IRQ = s.irq;
endmodule

// ### ocf_plant.sv
// Comparator and PWM source model facing the filter
`timescale 1ns/1ps
module ocf_plant (
  input wire logic clk,
  input wire logic [1:0] mode,
  output logic comp = 1'b0,
  output logic [5:0] pwm = 6'h2A
);
  logic [3:0] ph = 4'h0;
  // Quiet, steady overcurrent, or runs of twelve high cycles
  always @(posedge clk) begin
    ph <= ph + 4'h1;
    comp <= (mode == 2'h1) || (mode == 2'h2 && ph < 4'hC);
  end
endmodule

// ### ocf_props.sv
// Timing checker for the overcurrent filter ports
`timescale 1ns/1ps
module ocf_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic COMP_IN,
  input wire logic [5:0] PWM_IN,
  input wire logic [5:0] MOTOR_PWM_OUTPUTS,
  input wire logic CURRENT_LIMIT_FLAG
);
  logic [7:0] hi_run;
  logic [7:0] since_rst;
  // High run length and cycles since reset, both saturating
  always_ff @(posedge CLK) begin
    hi_run <= (RST || !COMP_IN) ? 8'h00 : hi_run + {7'h00, hi_run != 8'hFF};
    since_rst <= RST ? 8'h00 : since_rst + {7'h00, since_rst != 8'hFF};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  start_hold_a: assert property (since_rst < 8'h4C |-> !CURRENT_LIMIT_FLAG) else $error("flag in startup");
  settle_quiet_a: assert property (since_rst != 8'h00 && since_rst < 8'h4C |->
    MOTOR_PWM_OUTPUTS == $past(PWM_IN)) else $error("pwm cut in startup");
  run_needed_a: assert property ($rose(CURRENT_LIMIT_FLAG) |-> $past(hi_run, 4) >= 8'h0C) else $error("short run");
  low_restart_a: assert property ($rose(CURRENT_LIMIT_FLAG) |-> $past(COMP_IN, 5) && $past(COMP_IN, 11)) else $error("broken run");
  pwm_off_a: assert property ($rose(CURRENT_LIMIT_FLAG) |-> ##[2:8] MOTOR_PWM_OUTPUTS == 6'h00) else $error("pwm on");
  flag_first_a: assert property (MOTOR_PWM_OUTPUTS == 6'h00 && $past(MOTOR_PWM_OUTPUTS) != 6'h00 |->
    CURRENT_LIMIT_FLAG) else $error("cut without flag");
  cut_later_a: assert property ($rose(CURRENT_LIMIT_FLAG) |=> MOTOR_PWM_OUTPUTS != 6'h00) else $error("cut too soon");
  trip_c: cover property ($rose(CURRENT_LIMIT_FLAG));
  cut_c: cover property ($fell(MOTOR_PWM_OUTPUTS[1]));
  rise_c: cover property ($rose(COMP_IN));
endmodule
bind ocf_top ocf_props chk (.CLK(CLK), .RST(RST), .COMP_IN(COMP_IN), .PWM_IN(PWM_IN),
  .MOTOR_PWM_OUTPUTS(MOTOR_PWM_OUTPUTS), .CURRENT_LIMIT_FLAG(CURRENT_LIMIT_FLAG));

// ### test_overcurrent_sample_filter.sv
// Self-checking bench for the overcurrent sample filter
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
module test_overcurrent_sample_filter;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic COMP_IN;
  logic [5:0] PWM_IN;
  logic [5:0] MOTOR_PWM_OUTPUTS;
  logic CURRENT_LIMIT_FLAG;
  logic IRQ;
  logic [1:0] mode = 2'h0;
  logic [31:0] rd;
  int errors = 0;
  int n_tests = 0;
  int lat;
  ocf_top dut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .COMP_IN(COMP_IN), .PWM_IN(PWM_IN), .MOTOR_PWM_OUTPUTS(MOTOR_PWM_OUTPUTS),
    .CURRENT_LIMIT_FLAG(CURRENT_LIMIT_FLAG), .IRQ(IRQ));
  ocf_plant plant (.clk(CLK), .mode(mode), .comp(COMP_IN), .pwm(PWM_IN));
  // Clock and watchdog
  initial begin
    forever #20 CLK = ~CLK;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    errors++;
    tally_and_finish();
  end
  // One single-word transfer, address then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HADDR <= a;
    HWRITE <= wr;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    HSEL <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Startup hold, trip, status, clear, broken runs, filter latency
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    bus(1'b1, 32'h0000_0008, 32'h0000_0002);
    bus(1'b1, 32'h0000_0000, 32'h0000_0001);
    mode <= 2'h1;
    repeat (60) @(negedge CLK);
    `CHK("flag", 1'b0, CURRENT_LIMIT_FLAG)
    `CHK("pwm", 6'h2A, MOTOR_PWM_OUTPUTS)
    repeat (60) @(negedge CLK);
    `CHK("flag", 1'b1, CURRENT_LIMIT_FLAG)
    `CHK("pwm", 6'h00, MOTOR_PWM_OUTPUTS)
    `CHK("irq", 1'b1, IRQ)
    @(posedge CLK);
    mode <= 2'h0;
    // Let trips still in flight finish before the status read and clear
    repeat (40) @(posedge CLK);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK("status", 32'h0000_000B, rd)
    bus(1'b1, 32'h0000_0000, 32'h0000_0081);
    repeat (4) @(negedge CLK);
    `CHK("irq", 1'b0, IRQ)
    `CHK("pwm", 6'h2A, MOTOR_PWM_OUTPUTS)
    @(posedge CLK);
    mode <= 2'h2;
    repeat (200) @(negedge CLK);
    `CHK("flag", 1'b0, CURRENT_LIMIT_FLAG)
    for (int x = 0; x < 2; x++) begin
      // Quiet comparator long enough to empty the run counter and pipeline
      @(posedge CLK);
      mode <= 2'h0;
      repeat (40) @(posedge CLK);
      bus(1'b1, 32'h0000_0000, 32'h0000_0081 | 32'(x << 4));
      mode <= 2'h1;
      lat = 0;
      do begin @(negedge CLK); lat++; end while (CURRENT_LIMIT_FLAG !== 1'b1 && lat < 200);
      `CHK("latency", 1'b1, lat >= (1 + x) * 16 - 4 && lat <= (1 + x) * 16 + 8)
    end
    // Control, mask and unmapped read back
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0091, rd)
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    `CHK("mask", 32'h0000_0002, rd)
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    `CHK("resp", 1'b0, HRESP)
    tally_and_finish();
  end
endmodule
